// ==== bench/sram_array_model.sv ====
// Behavioural storage array standing behind the burst SRAM control block.
`timescale 1ns/1ps
module sram_array_model (
   input logic clk,
   input sram_ctl_pkg::array_req_t array_req,
   input logic array_req_valid,
   output logic [35:0] array_rdata
);
   logic [35:0] mem_r [16];
   // Start from known contents so a wrong address shows as wrong data.
   initial begin
      for (int i = 0; i < 16; i++) begin
         mem_r[i] = 36'h000000000;
      end
   end
   // Only the requested lanes change; the other lanes keep their data.
   always @(posedge clk) begin
      if (array_req_valid && !array_req.rd) begin
         for (int g = 0; g < 4; g++) begin
            if (array_req.lanes[g]) begin
               mem_r[array_req.addr[3:0]][9*g +: 9] <=
                  array_req.wdata[9*g +: 9];
            end
         end
      end
   end
   // Outside a read the data lines show the inverse, never a stale match.
   assign array_rdata = (array_req_valid && array_req.rd) ?
      mem_r[array_req.addr[3:0]] : ~mem_r[array_req.addr[3:0]];
endmodule

// ==== bench/sram_ctl_chk.sv ====
// Concurrent checks on the ports of the burst SRAM control block.
`timescale 1ns/1ps
module sram_ctl_chk #(parameter bit NARROW_MODE = 1'b0) (
   input logic clk,
   input logic rst_n,
   input logic clk_en,
   input logic chip_enable_n,
   input logic high_select,
   input logic low_select_n,
   input logic proc_addr_strobe_n,
   input logic ctrl_addr_strobe_n,
   input logic all_bytes_write_n,
   input logic out_enable_n,
   input logic sleep_request,
   input logic linear_order_select_n,
   input logic [17:0] addr_in,
   input logic [35:0] array_rdata,
   input logic [35:0] dq_out,
   input logic dq_oe_n,
   input logic array_req_valid,
   input sram_ctl_pkg::array_req_t array_req,
   input sram_ctl_pkg::cycle_kind_t cycle_kind
);
   // Request terms decoded from the pins and the reported cycle kind.
   wire go = clk_en && !sleep_request;
   wire sel = !chip_enable_n && high_select && !low_select_n;
   wire [3:0] all_l = NARROW_MODE ? 4'h3 : 4'hf;
   wire step = cycle_kind == sram_ctl_pkg::CYC_NEXT_READ ||
      cycle_kind == sram_ctl_pkg::CYC_NEXT_WRITE;
   wire hold = cycle_kind == sram_ctl_pkg::CYC_HOLD_READ ||
      cycle_kind == sram_ctl_pkg::CYC_HOLD_WRITE;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   AST_DESEL: assert property (go && chip_enable_n && !ctrl_addr_strobe_n
      |=> !array_req_valid) else $error("Deselect made an access.");
   AST_PROC_RD: assert property (go && sel && !proc_addr_strobe_n
      |=> array_req_valid && array_req.rd && array_req.addr == $past(addr_in))
      else $error("Processor strobe did not start a read.");
   AST_ALL_LANES: assert property (go && sel && proc_addr_strobe_n &&
      !ctrl_addr_strobe_n && !all_bytes_write_n |=> !array_req.rd &&
      array_req.lanes == all_l) else $error("All-lane write decoded wrong.");
   AST_OE: assert property (out_enable_n |-> dq_oe_n)
      else $error("Pins driven with output enable high.");
   AST_SLEEP: assert property (sleep_request |-> dq_oe_n)
      else $error("Pins driven during sleep.");
   AST_RD_PIPE: assert property (go && array_req_valid && array_req.rd
      |=> dq_out == $past(array_rdata)) else $error("Read data lost.");
   AST_HOLD: assert property (hold && $past(array_req_valid)
      |-> array_req.addr == $past(array_req.addr))
      else $error("Suspend moved the address.");
   AST_LINEAR: assert property (step && !linear_order_select_n &&
      $past(array_req_valid) |-> array_req.addr[1:0] ==
      $past(array_req.addr[1:0]) + 2'h1) else $error("Linear step wrong.");
   AST_UPPER: assert property ((step || hold) && $past(array_req_valid)
      |-> array_req.addr[17:2] == $past(array_req.addr[17:2]))
      else $error("Burst changed upper address bits.");
   // Main scenarios reached.
   COV_NEXT_WR: cover property (cycle_kind == sram_ctl_pkg::CYC_NEXT_WRITE);
   COV_HOLD_WR: cover property (cycle_kind == sram_ctl_pkg::CYC_HOLD_WRITE);
   COV_SLEEP: cover property (sleep_request && !out_enable_n);
endmodule
bind sync_burst_sram_control sram_ctl_chk #(.NARROW_MODE(NARROW_MODE)) chk (
   .clk, .rst_n, .clk_en, .chip_enable_n, .high_select, .low_select_n,
   .proc_addr_strobe_n, .ctrl_addr_strobe_n, .all_bytes_write_n,
   .out_enable_n, .sleep_request, .linear_order_select_n, .addr_in,
   .array_rdata, .dq_out, .dq_oe_n, .array_req_valid, .array_req,
   .cycle_kind);

// ==== bench/sync_burst_sram_control_tb.sv ====
// Self-checking bench of the burst SRAM control block.
`timescale 1ns/1ps
module sync_burst_sram_control_tb;
   logic clk = 0, rst_n = 0, clk_en = 1, chip_enable_n = 1;
   logic high_select = 1, low_select_n = 0, proc_addr_strobe_n = 1;
   logic ctrl_addr_strobe_n = 1, burst_step_n = 1, all_bytes_write_n = 1;
   logic byte_write_gate_n = 1, out_enable_n = 0, sleep_request = 0;
   logic linear_order_select_n = 0, dq_oe_n, array_req_valid;
   logic standby, sleeping;
   logic [3:0] lane_write_n = 4'hf;
   logic [17:0] addr_in = 18'h00000;
   logic [35:0] dq_in = 36'h000000000, dq_out, array_rdata;
   sram_ctl_pkg::array_req_t array_req, narrow_req;
   sram_ctl_pkg::cycle_kind_t cycle_kind;
   int n_fail = 0, cmp_count = 0, cyc_n = 0;
   // Clock and the two sides of the block.
   always #50 clk = ~clk;
   sync_burst_sram_control uut (.clk, .rst_n, .clk_en, .chip_enable_n,
      .high_select, .low_select_n, .proc_addr_strobe_n, .ctrl_addr_strobe_n,
      .burst_step_n, .all_bytes_write_n, .byte_write_gate_n, .lane_write_n,
      .out_enable_n, .sleep_request, .linear_order_select_n, .addr_in, .dq_in,
      .dq_out, .dq_oe_n, .array_req, .array_req_valid, .array_rdata,
      .cycle_kind, .standby, .sleeping);
   sram_array_model mem (.clk, .array_req, .array_req_valid, .array_rdata);
   // A narrow twin on the same pins shows that lanes three and four vanish.
   sync_burst_sram_control #(.NARROW_MODE(1'b1)) uut_narrow (.clk, .rst_n,
      .clk_en, .chip_enable_n, .high_select, .low_select_n,
      .proc_addr_strobe_n, .ctrl_addr_strobe_n, .burst_step_n,
      .all_bytes_write_n, .byte_write_gate_n, .lane_write_n, .out_enable_n,
      .sleep_request, .linear_order_select_n, .addr_in, .dq_in, .dq_out(),
      .dq_oe_n(), .array_req(narrow_req), .array_req_valid(), .array_rdata,
      .cycle_kind(), .standby(), .sleeping());
   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic ck(input logic [63:0] s, input logic [63:0] e);
      cmp_count++;
      if (s !== e) begin
         n_fail++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   // One request driven at a rising edge; returns at the next falling edge.
   task automatic cyc(input logic ce, p, c, s, g, b, input logic [3:0] w,
         input logic [17:0] a, input logic [35:0] d);
      @(posedge clk);
      chip_enable_n <= ce;
      proc_addr_strobe_n <= p;
      ctrl_addr_strobe_n <= c;
      burst_step_n <= s;
      all_bytes_write_n <= g;
      byte_write_gate_n <= b;
      lane_write_n <= w;
      addr_in <= a;
      dq_in <= d;
      @(negedge clk);
   endtask
   task automatic desel();
      cyc(1, 1, 0, 1, 1, 1, 4'hf, 18'h00000, 36'h000000000);
   endtask
   task automatic nxt(input logic s, g, input logic [35:0] d);
      cyc(1, 1, 1, s, g, 1, 4'hf, 18'h00000, d);
   endtask
   task automatic wr(input logic [17:0] a, input logic [35:0] d);
      cyc(0, 1, 0, 1, 0, 1, 4'hf, a, d);
      desel();
      ck(array_req, {a, 1'b0, 4'hf, d});
      ck(narrow_req.lanes, 4'h3);
   endtask
   task automatic rd(input logic [17:0] a, input logic [35:0] e);
      cyc(0, 0, 1, 1, 1, 1, 4'hf, a, 36'h000000000);
      desel();
      desel();
      ck(dq_out, e);
      ck(dq_oe_n, 1'b0);
   endtask
   task automatic t_lanes();
      wr(18'h00005, 36'hfffffffff);
      cyc(0, 1, 0, 1, 1, 0, 4'ha, 18'h00005, 36'h000000000);
      desel();
      ck(array_req.lanes, 4'h5);
      ck(narrow_req.lanes, 4'h1);
      cyc(0, 1, 0, 1, 1, 1, 4'h0, 18'h00005, 36'h000000000);
      desel();
      ck(array_req.rd, 1'b1);
      cyc(0, 0, 1, 1, 0, 1, 4'hf, 18'h00005, 36'h000000000);
      desel();
      ck(array_req.rd, 1'b1);
      rd(18'h00005, 36'hff803fe00);
      $display("lanes done");
   endtask
   task automatic t_burst();
      for (int lin = 0; lin < 2; lin++) begin
         linear_order_select_n <= lin[0];
         desel();
         cyc(0, 0, 1, 1, 1, 1, 4'hf, 18'h048d1, 36'h000000000);
         for (int i = 0; i < 5; i++) begin
            nxt(0, 1, 36'h000000000);
            ck(array_req.addr, {16'h1234, lin ? 2'h1 ^ 2'(i) : 2'h1 + 2'(i)});
            if (i > 0) ck(cycle_kind, sram_ctl_pkg::CYC_NEXT_READ);
         end
         desel();
      end
      $display("burst done");
   endtask
   task automatic t_suspend();
      cyc(0, 1, 0, 1, 0, 1, 4'hf, 18'h12342, 36'h000000000);
      nxt(1, 0, 36'h123456789);
      nxt(0, 0, 36'h9abcdef01);
      ck(array_req, {18'h12342, 1'b0, 4'hf, 36'h123456789});
      nxt(1, 1, 36'h000000000);
      ck(array_req, {18'h12343, 1'b0, 4'hf, 36'h9abcdef01});
      desel();
      ck(array_req.addr, 18'h12343);
      ck(cycle_kind, sram_ctl_pkg::CYC_HOLD_READ);
      rd(18'h12342, 36'h123456789);
      rd(18'h12343, 36'h9abcdef01);
      $display("suspend done");
   endtask
   task automatic t_desel();
      for (int k = 0; k < 2; k++) begin
         cyc(0, 0, 1, 1, 1, 1, 4'hf, 18'h00001, 36'h000000000);
         if (k) low_select_n <= 1;
         else high_select <= 0;
         cyc(0, 0, 1, 1, 1, 1, 4'hf, 18'h00002, 36'h000000000);
         nxt(0, 1, 36'h000000000);
         ck(array_req_valid, 1'b0);
         high_select <= 1;
         low_select_n <= 0;
         desel();
         ck(array_req_valid, 1'b0);
      end
      $display("deselect done");
   endtask
   task automatic t_sleep();
      cyc(0, 0, 1, 1, 1, 1, 4'hf, 18'h00005, 36'h000000000);
      nxt(1, 1, 36'h000000000);
      nxt(1, 1, 36'h000000000);
      ck(dq_out, 36'hff803fe00);
      ck(dq_oe_n, 1'b0);
      out_enable_n = 1;
      #1 ck(dq_oe_n, 1'b1);
      out_enable_n = 0;
      #1 ck(dq_oe_n, 1'b0);
      sleep_request = 1;
      #1 ck(dq_oe_n, 1'b1);
      cyc(0, 0, 1, 1, 1, 1, 4'hf, 18'h00005, 36'h000000000);
      ck(sleeping, 1'b1);
      ck(array_req_valid, 1'b0);
      desel();
      ck(array_req_valid, 1'b0);
      sleep_request = 0;
      desel();
      nxt(0, 1, 36'h000000000);
      desel();
      ck(array_req_valid, 1'b0);
      ck(standby, 1'b1);
      // Clock enable low freezes the block: a read strobe makes no access.
      @(posedge clk);
      clk_en <= 1'b0;
      cyc(0, 0, 1, 1, 1, 1, 4'hf, 18'h00005, 36'h000000000);
      desel();
      ck(array_req_valid, 1'b0);
      ck(standby, 1'b1);
      $display("sleep done");
   endtask
   // Cuts a hung run short.
   always @(posedge clk) begin
      cyc_n++;
      if (cyc_n > 3000) begin
         n_fail++;
         end_sim();
      end
   end
   // Main sequence.
   initial begin
      repeat (12) @(posedge clk);
      rst_n <= 1;
      @(negedge clk);
      ck(dq_oe_n, 1'b1);
      ck(array_req_valid, 1'b0);
      t_lanes();
      t_burst();
      t_suspend();
      t_desel();
      t_sleep();
      end_sim();
   end
endmodule

// ==== hw/sram_ctl_pkg.sv ====
// Shared constants and types of the synchronous burst SRAM control block.
package sram_ctl_pkg;

   // Address and data widths of the wide configuration.
   localparam int ADDR_W = 18;
   localparam int DATA_W = 36;
   localparam int LANES = 4;
   localparam int LANE_W = 9;
   localparam int BURST_W = 2;

   // Lane masks for the wide and the narrow configuration.
   localparam logic [3:0] LANE_MASK_WIDE = 4'hf;
   localparam logic [3:0] LANE_MASK_NARROW = 4'h3;
   localparam logic [3:0] LANE_NONE = 4'h0;

   // Burst counter step and its value at the start of a burst.
   localparam logic [1:0] BURST_STEP = 2'h1;
   localparam logic [1:0] BURST_START = 2'h0;

   // Values after reset.
   localparam logic [17:0] ADDR_RST = 18'h00000;
   localparam logic [35:0] DATA_RST = 36'h000000000;

   // Kind of synchronous cycle decoded on a clock edge.
   typedef enum logic [2:0] {
      CYC_NONE,
      CYC_DESELECT,
      CYC_BEGIN_READ,
      CYC_BEGIN_WRITE,
      CYC_NEXT_READ,
      CYC_NEXT_WRITE,
      CYC_HOLD_READ,
      CYC_HOLD_WRITE
   } cycle_kind_t;

   // Burst tracking state.
   typedef enum logic [1:0] {
      BURST_IDLE,
      BURST_ACTIVE,
      BURST_SLEEP
   } burst_state_t;

   // One access presented to the storage array.
   typedef struct packed {
      logic [17:0] addr;
      logic rd;
      logic [3:0] lanes;
      logic [35:0] wdata;
   } array_req_t;

endpackage

// ==== hw/sync_burst_sram_control.sv ====
// Control logic of a pipelined synchronous burst SRAM.
//
// Implementation choices: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps

// What this block does and what its controller must keep
// R01: Deselect edge uses no address and floats data pins on the listed select cases.
// R02: Selected with processor strobe low loads address and starts a read burst.
// R03: Selected, controller strobe only, loads address; write if lanes requested, else read.
// R04: No strobe and burst step low reads from the next burst address.
// R05: No strobe, burst step low and write requested writes at the next address.
// R06: No strobe and burst step high holds the counter and rereads current address.
// R07: No strobe, burst step high and write requested writes at the current address.
// R08: All-bytes write writes every lane; gated lane inputs select lanes; else read.
// R09: Any mix of lanes may be written together; other lanes stay unchanged.
// R10: In the narrow configuration lanes three and four have no effect.
// R11: Output enable acts asynchronously, floats pins when high, ignored on writes.
// R12: Cycle decode runs only while sleep is low; sleep floats the data pins.
// R13: Controller holds synchronous pins at levels selecting the intended operation.
// R14: Order select high steps low address bits as start XOR count 0..3.
// R15: Order select low steps low address bits linearly, plus one modulo four.
// R16: After the fourth address the counter wraps to the burst start value.
// R17: Controller keeps burst order select static during operation.
// R18: Controller keeps the device deselected when leaving sleep.
// R19: Both address strobes start read bursts identically.
// R20: Read data appears after the edge following the registered address.
// R21: The burst counter changes only the two lowest address bits.
module sync_burst_sram_control #(
   parameter bit NARROW_MODE = 1'b0
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire logic chip_enable_n,
   input wire logic high_select,
   input wire logic low_select_n,
   input wire logic proc_addr_strobe_n,
   input wire logic ctrl_addr_strobe_n,
   input wire logic burst_step_n,
   input wire logic all_bytes_write_n,
   input wire logic byte_write_gate_n,
   input wire logic [3:0] lane_write_n,
   input wire logic out_enable_n,
   input wire logic sleep_request,
   input wire logic linear_order_select_n,
   input wire logic [17:0] addr_in,
   input wire logic [35:0] dq_in,
   output logic [35:0] dq_out,
   output logic dq_oe_n,
   output sram_ctl_pkg::array_req_t array_req,
   output logic array_req_valid,
   input wire logic [35:0] array_rdata,
   output sram_ctl_pkg::cycle_kind_t cycle_kind,
   output logic standby,
   output logic sleeping
);

   // Registered state.
   sram_ctl_pkg::burst_state_t state_r;
   sram_ctl_pkg::burst_state_t state_nxt;
   logic [17:0] base_r;
   logic [17:0] base_nxt;
   logic [1:0] start_r;
   logic [1:0] start_nxt;
   logic [1:0] count_r;
   logic [1:0] count_nxt;
   sram_ctl_pkg::array_req_t req_r;
   sram_ctl_pkg::array_req_t req_nxt;
   logic req_valid_r;
   logic req_valid_nxt;
   logic [35:0] dout_r;
   logic [35:0] dout_nxt;
   logic drive_r;
   logic drive_nxt;
   sram_ctl_pkg::cycle_kind_t kind_r;
   sram_ctl_pkg::cycle_kind_t kind_nxt;

   // Decode wires.
   logic selected;
   logic any_strobe;
   logic deselect;
   logic begin_proc;
   logic begin_ctrl;
   logic no_strobe;
   logic burst_live;
   logic [3:0] lane_mask;
   logic [3:0] lane_raw;
   logic [3:0] lanes;
   logic write_req;
   logic [35:0] wdata_lanes;
   logic [1:0] count_step;
   logic [1:0] low_next;
   logic [1:0] low_hold;
   logic begin_cyc;
   logic next_cyc;
   logic hold_cyc;
   logic access;
   logic access_write;
   logic [17:0] access_addr;
   logic pins_receive;

   // The chip is selected only when all three selects are active.
   // A secondary select alone never starts anything; it only turns a
   // strobe into a deselect while the primary select is active.
   assign selected = ~chip_enable_n & high_select & ~low_select_n;
   assign any_strobe = ~proc_addr_strobe_n | ~ctrl_addr_strobe_n;

   // Deselect cases: primary off with controller strobe, or a strobe with
   // a secondary select off.
   // A deselect ends any live burst, so a later continue is ignored.
   assign deselect = (chip_enable_n & ~ctrl_addr_strobe_n) |
                     (~chip_enable_n & ~selected & any_strobe); // [R01]

   // A processor strobe on a selected chip always starts a read, whatever the write inputs say.
   // It wins over the controller strobe, so a write needs the processor
   // strobe held high.
   assign begin_proc = selected & ~proc_addr_strobe_n; // [R02] [R19]

   // A controller strobe alone starts a read or a write burst.
   assign begin_ctrl = selected & proc_addr_strobe_n &
                       ~ctrl_addr_strobe_n; // [R03] [R19]

   // Without a new address strobe the burst continues or is suspended.
   // With the primary select off a processor strobe is meant for another
   // device, so it does not start a new burst here.
   assign no_strobe = ctrl_addr_strobe_n &
                      (proc_addr_strobe_n | chip_enable_n);

   // Continue and suspend cycles act only inside a live burst.
   // Outside a burst there is no valid base, so stepping would read junk.
   assign burst_live = (state_r == sram_ctl_pkg::BURST_ACTIVE);

   // Lanes that exist in this configuration.
   // Missing lanes are masked once, so a stray lane input in the narrow
   // configuration can neither write nor turn a read into a write.
   assign lane_mask = NARROW_MODE ? sram_ctl_pkg::LANE_MASK_NARROW :
                      sram_ctl_pkg::LANE_MASK_WIDE; // [R10]

   // Per-lane write decode and per-lane data gating.
   // Unwritten lanes carry zero toward the array, so a stale pin value can
   // never be mistaken for write data.
   genvar g;
   generate
      for (g = 0; g < sram_ctl_pkg::LANES; g++) begin : g_lane
         assign lane_raw[g] = ~all_bytes_write_n |
                              (~byte_write_gate_n & ~lane_write_n[g]); // [R08]
         assign wdata_lanes[g*sram_ctl_pkg::LANE_W +: sram_ctl_pkg::LANE_W] =
            lanes[g] ? dq_in[g*sram_ctl_pkg::LANE_W +: sram_ctl_pkg::LANE_W] :
            9'h000; // [R09]
      end
   endgenerate

   // Only existing lanes are written; no lane at all means a read.
   assign lanes = lane_raw & lane_mask; // [R09] [R10]
   assign write_req = |lanes; // [R08]

   // Next counter value wraps modulo four, so a fourth step returns to start.
   // A two-bit counter needs no wrap logic of its own.
   assign count_step = count_r + sram_ctl_pkg::BURST_STEP; // [R16]

   // Low address bits for the advanced and the held counter.
   // Both orders are formed from the start value and the count, not from
   // the last address, so a suspended cycle cannot skew the sequence.
   assign low_next = linear_order_select_n ?
                     (start_r ^ count_step) : // [R14]
                     (start_r + count_step); // [R15]
   assign low_hold = linear_order_select_n ?
                     (start_r ^ count_r) : // [R14]
                     (start_r + count_r); // [R15]

   // Cycle classes, all gated by sleep.
   // A strobe seen while sleep is high is lost, not deferred.
   assign begin_cyc = ~sleep_request & (begin_proc | begin_ctrl); // [R12]
   assign next_cyc = ~sleep_request & no_strobe & burst_live &
                     ~burst_step_n; // [R04] [R05]
   assign hold_cyc = ~sleep_request & no_strobe & burst_live &
                     burst_step_n; // [R06] [R07]
   assign access = begin_cyc | next_cyc | hold_cyc;

   // Writes come from a controller-strobed start or from a continue or suspend cycle of a live burst.
   assign access_write = write_req & (begin_ctrl | next_cyc | hold_cyc);

   // Address of this access; continue and suspend take upper bits from the burst base.
   // Only the two low bits ever come from the counter.
   assign access_addr = begin_cyc ? addr_in :
                        next_cyc ? {base_r[17:2], low_next} : // [R04] [R21]
                        {base_r[17:2], low_hold}; // [R06] [R21]

   // Pins receive data during any write cycle, whatever output enable says.
   // A write takes priority over a pending read output, so the pins never
   // fight the controller.
   assign pins_receive = access & access_write; // [R11]

   // Next burst state, base and counter.
   // Sleep drops the burst and leaving sleep returns to idle, which is why
   // the controller must keep the chip deselected on the way out.
   always_comb begin
      state_nxt = state_r;
      base_nxt = base_r;
      start_nxt = start_r;
      count_nxt = count_r;
      if (sleep_request) begin
         state_nxt = sram_ctl_pkg::BURST_SLEEP; // [R12]
      end else begin
         case (state_r)
            sram_ctl_pkg::BURST_SLEEP: begin
               state_nxt = sram_ctl_pkg::BURST_IDLE; // [R18]
            end
            sram_ctl_pkg::BURST_IDLE,
            sram_ctl_pkg::BURST_ACTIVE: begin
               if (deselect) begin
                  state_nxt = sram_ctl_pkg::BURST_IDLE; // [R01]
               end else if (begin_cyc) begin
                  state_nxt = sram_ctl_pkg::BURST_ACTIVE;
                  base_nxt = addr_in; // [R02] [R03]
                  start_nxt = addr_in[1:0];
                  count_nxt = sram_ctl_pkg::BURST_START;
               end else if (next_cyc) begin
                  count_nxt = count_step; // [R04] [R05] [R16]
               end
            end
            default: begin
               state_nxt = sram_ctl_pkg::BURST_IDLE;
            end
         endcase
      end
   end

   // Request to the array for this edge, and the decoded cycle kind.
   // The address is held between accesses so the array sees stable inputs.
   always_comb begin
      req_nxt.addr = access ? access_addr : req_r.addr;
      req_nxt.rd = access & ~access_write;
      req_nxt.lanes = (access & access_write) ? lanes :
                      sram_ctl_pkg::LANE_NONE; // [R09]
      req_nxt.wdata = (access & access_write) ? wdata_lanes :
                      sram_ctl_pkg::DATA_RST;
      req_valid_nxt = access;
      if (sleep_request) begin
         kind_nxt = sram_ctl_pkg::CYC_NONE;
      end else if (deselect) begin
         kind_nxt = sram_ctl_pkg::CYC_DESELECT;
      end else if (begin_cyc) begin
         kind_nxt = access_write ? sram_ctl_pkg::CYC_BEGIN_WRITE :
                    sram_ctl_pkg::CYC_BEGIN_READ;
      end else if (next_cyc) begin
         kind_nxt = access_write ? sram_ctl_pkg::CYC_NEXT_WRITE :
                    sram_ctl_pkg::CYC_NEXT_READ;
      end else if (hold_cyc) begin
         kind_nxt = access_write ? sram_ctl_pkg::CYC_HOLD_WRITE :
                    sram_ctl_pkg::CYC_HOLD_READ;
      end else begin
         kind_nxt = sram_ctl_pkg::CYC_NONE;
      end
   end

   // Read data is captured one edge after its address was registered.
   // The drive flag lasts one cycle per read; back-to-back reads keep it up.
   assign dout_nxt = (req_valid_r & req_r.rd) ? array_rdata : dout_r; // [R20]
   assign drive_nxt = req_valid_r & req_r.rd & ~sleep_request; // [R20] [R12]

   // State registers; reset is synchronous and clock enable freezes all.
   // Clock enable low keeps a burst exactly where it stood.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state_r <= sram_ctl_pkg::BURST_IDLE;
         base_r <= sram_ctl_pkg::ADDR_RST;
         start_r <= sram_ctl_pkg::BURST_START;
         count_r <= sram_ctl_pkg::BURST_START;
      end else if (clk_en) begin
         state_r <= state_nxt;
         base_r <= base_nxt;
         start_r <= start_nxt;
         count_r <= count_nxt;
      end
   end

   // Pipeline registers toward the array and the data pins.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         req_r <= '0;
         req_valid_r <= 1'b0;
         dout_r <= sram_ctl_pkg::DATA_RST;
         drive_r <= 1'b0;
         kind_r <= sram_ctl_pkg::CYC_NONE;
      end else if (clk_en) begin
         req_r <= req_nxt;
         req_valid_r <= req_valid_nxt;
         dout_r <= dout_nxt;
         drive_r <= drive_nxt;
         kind_r <= kind_nxt;
      end
   end

   // Pin drive follows output enable and sleep without waiting for a clock.
   // Output enable is not registered, since it must act within the cycle.
   assign dq_oe_n = ~(drive_r & ~out_enable_n & ~sleep_request &
                      ~pins_receive); // [R11] [R12]
   assign dq_out = dout_r;

   // Array request and status outputs.
   assign array_req = req_r;
   assign array_req_valid = req_valid_r;
   assign cycle_kind = kind_r;
   assign standby = (state_r == sram_ctl_pkg::BURST_IDLE);
   assign sleeping = (state_r == sram_ctl_pkg::BURST_SLEEP);

endmodule
